// file: abx_exec.sv
`timescale 1ns/1ps
// Overview of operation
// - Fixup adds 6 per nibble over 9 or with carry, sets carry on overflow.
// - Fixup only sets carry, never clears it; signed excess flag untouched.
// - Decrement subtracts one from A, bank, direct or indirect byte, no flags.
// - Decrement opcodes 00010100, 00011rrr, 00010101 plus address, and 0001011i.
// - Port read-modify-write for inc, dec and count-down uses the output latch.
// - Divide puts quotient in A, remainder in B, clears carry and excess flag.
// - Divide by zero sets excess flag, clears carry, A and B undefined.
// - Count-down decrements bank or direct byte, branches when result nonzero.
// - Count-down opcodes 11011rrr plus rel and 11010101 plus address and rel.
// - Increment adds one to A, bank, direct or indirect byte, no flags.
// - Increment opcodes 00000100, 00001rrr, 00000101 plus address, 0000011i.
// - Pointer increment carries low byte into high byte, opcode 10100011.
// - Bit-set branch advances PC by 3 and adds displacement when bit is one.
// - Branch-and-clear clears a set bit and branches; opcode 00010000.
// - Branch-and-clear on a port bit reads the output latch.
// - Carry branch advances PC by 2, adds displacement when carry set.
// - Carry branch opcode 01000000; bit-set branch opcode 00100000.
module abx_exec (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Instruction
  input wire logic i_valid,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_byte2,
  input wire logic [7:0] i_byte3,
  input wire logic [15:0] i_pc,
  // Architectural state
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_breg,
  input wire logic i_carry,
  input wire logic i_nibble_carry_flag,
  input wire logic i_signed_excess_flag,
  input wire logic [15:0] i_pointer_pair,
  // Operand read, latch value for port locations
  input wire logic [7:0] i_operand,
  input wire logic i_bit_value,
  // Result
  output logic o_done,
  output abx_pkg::abx_result_s o_result
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire is_fix = i_opcode == abx_pkg::OP_BCD_FIXUP;
  wire is_dec_a = i_opcode == abx_pkg::OP_DEC_A;
  wire is_dec_rn = (i_opcode & abx_pkg::MASK_RN) == abx_pkg::OP_DEC_RN;
  wire is_dec_dir = i_opcode == abx_pkg::OP_DEC_DIR;
  wire is_dec_ind = (i_opcode & abx_pkg::MASK_IND) == abx_pkg::OP_DEC_IND;
  wire is_inc_a = i_opcode == abx_pkg::OP_INC_A;
  wire is_inc_rn = (i_opcode & abx_pkg::MASK_RN) == abx_pkg::OP_INC_RN;
  wire is_inc_dir = i_opcode == abx_pkg::OP_INC_DIR;
  wire is_inc_ind = (i_opcode & abx_pkg::MASK_IND) == abx_pkg::OP_INC_IND;
  wire is_inc_ptr = i_opcode == abx_pkg::OP_INC_PTR;
  wire is_div = i_opcode == abx_pkg::OP_DIV;
  wire is_cdb_rn = (i_opcode & abx_pkg::MASK_RN) == abx_pkg::OP_CDB_RN;
  wire is_cdb_dir = i_opcode == abx_pkg::OP_CDB_DIR;
  wire is_bobs = i_opcode == abx_pkg::OP_BOBS;
  wire is_bacb = i_opcode == abx_pkg::OP_BACB;
  wire is_boc = i_opcode == abx_pkg::OP_BOC;
  wire is_dec = is_dec_a | is_dec_rn | is_dec_dir | is_dec_ind;
  wire is_inc = is_inc_a | is_inc_rn | is_inc_dir | is_inc_ind;
  wire is_cdb = is_cdb_rn | is_cdb_dir;
  wire acc_form = is_dec_a | is_inc_a;
  wire rn_form = is_dec_rn | is_inc_rn | is_cdb_rn;
  wire dir_form = is_dec_dir | is_inc_dir | is_cdb_dir;
  wire ind_form = is_dec_ind | is_inc_ind;
  wire bit_form = is_bobs | is_bacb;
  wire known = is_fix | is_dec | is_inc | is_inc_ptr | is_div | is_cdb | bit_form | is_boc;

  // ----------------------------------------
  // Byte arithmetic
  // ----------------------------------------
  // Memory operands arrive already read from the port output latch, so
  // read-modify-write never sees the pin level.
  wire [7:0] src = acc_form ? i_acc : i_operand;
  wire [7:0] minus_one = src - 8'h01;
  wire [7:0] plus_one = src + 8'h01;
  wire [15:0] ptr_next = i_pointer_pair + 16'h0001;

  // Decimal fixup, done in two stages so the high test sees the low carry.
  wire lo_fix = (i_acc[3:0] > abx_pkg::BCD_LIMIT) | i_nibble_carry_flag;
  wire [8:0] stage1 = {1'b0, i_acc} + (lo_fix ? {5'h00, abx_pkg::BCD_FIX} : 9'h000);
  wire c1 = i_carry | stage1[8];
  wire hi_fix = (stage1[7:4] > abx_pkg::BCD_LIMIT) | c1;
  wire [8:0] stage2 = {1'b0, stage1[7:0]} +
    (hi_fix ? {1'b0, abx_pkg::BCD_FIX, 4'h0} : 9'h000);
  wire fix_carry = c1 | stage2[8];

  // Divide by zero yields all ones here; software must not rely on it.
  wire div_zero = i_breg == 8'h00;
  wire [7:0] quot = div_zero ? 8'hff : i_acc / i_breg;
  wire [7:0] rem = div_zero ? 8'hff : i_acc % i_breg;

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  wire three_byte = bit_form | is_cdb_dir;
  wire [15:0] pc_seq = i_pc + (three_byte ? abx_pkg::LEN_THREE : abx_pkg::LEN_TWO);
  wire [7:0] rel = three_byte ? i_byte3 : i_byte2;
  wire [15:0] pc_jump = pc_seq + {{8{rel[7]}}, rel};
  wire take = (is_cdb & (minus_one != 8'h00)) |
    (bit_form & i_bit_value) |
    (is_boc & i_carry);
  wire is_branch = is_cdb | bit_form | is_boc;
  wire [15:0] pc_new = is_branch ? (take ? pc_jump : pc_seq) : i_pc + 16'h0001;

  abx_pkg::abx_target_e tgt;
  assign tgt = acc_form ? abx_pkg::ABX_OP_ACC :
    rn_form ? abx_pkg::ABX_OP_BANK :
    dir_form ? abx_pkg::ABX_OP_DIRECT :
    ind_form ? abx_pkg::ABX_OP_INDIRECT :
    bit_form ? abx_pkg::ABX_OP_BIT : abx_pkg::ABX_OP_NONE;

  abx_pkg::abx_result_s res_d, res_q;
  logic done_q;

  always_comb begin
    res_d = '0;
    res_d.acc = i_acc;
    res_d.breg = i_breg;
    res_d.carry = i_carry;
    res_d.signed_excess_flag = i_signed_excess_flag;
    res_d.pointer_pair = i_pointer_pair;
    res_d.pc = pc_new;
    res_d.target = tgt;
    res_d.sel = i_opcode[2:0];
    res_d.known = known;
    if (is_fix) begin
      res_d.acc = stage2[7:0];
      res_d.carry = fix_carry;
    end
    if (is_dec | is_cdb) begin
      res_d.wr_data = minus_one;
      res_d.wr_en = !acc_form;
      if (acc_form) begin
        res_d.acc = minus_one;
      end
    end
    if (is_inc) begin
      res_d.wr_data = plus_one;
      res_d.wr_en = !acc_form;
      if (acc_form) begin
        res_d.acc = plus_one;
      end
    end
    if (is_inc_ptr) begin
      res_d.pointer_pair = ptr_next;
    end
    if (is_div) begin
      res_d.acc = quot;
      res_d.breg = rem;
      res_d.carry = 1'b0;
      res_d.signed_excess_flag = div_zero;
    end
    if (is_bacb & i_bit_value) begin
      res_d.bit_clear = 1'b1;
    end
  end

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      res_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= i_valid;
      if (i_valid) begin
        res_q <= res_d;
      end
    end
  end

  assign o_done = done_q;
  assign o_result = res_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_FIX_CARRY_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix && i_carry) |=> o_result.carry)
    else $error("Fixup cleared carry.");
  AST_FIX_EXCESS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix) |=> o_result.signed_excess_flag == $past(i_signed_excess_flag))
    else $error("Fixup changed excess flag.");
  AST_FIX_LOW: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix && !i_nibble_carry_flag && !i_carry && i_acc == 8'h0a)
    |=> o_result.acc == 8'h10)
    else $error("Fixup low nibble wrong.");
  AST_DEC_WRAP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_dec_a && i_acc == 8'h00) |=> o_result.acc == 8'hff &&
    o_result.carry == $past(i_carry))
    else $error("Decrement wrap wrong.");
  AST_INC_WRAP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_inc_dir && i_operand == 8'hff) |=> o_result.wr_data == 8'h00 &&
    o_result.wr_en && o_result.target == abx_pkg::ABX_OP_DIRECT)
    else $error("Increment wrap wrong.");
  AST_PTR_CARRY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_inc_ptr && i_pointer_pair == 16'h12ff) |=> o_result.pointer_pair == 16'h1300)
    else $error("Pointer carry lost.");
  AST_DIV_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_div && i_breg == 8'h00) |=> o_result.signed_excess_flag && !o_result.carry)
    else $error("Divide by zero flags wrong.");
  AST_DIV_VAL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_div && i_acc == 8'hfb && i_breg == 8'h12) |=>
    o_result.acc == 8'h0d && o_result.breg == 8'h11 && !o_result.signed_excess_flag)
    else $error("Divide result wrong.");
  AST_CDB_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_cdb_rn && i_operand == 8'h01) |=> o_result.pc == $past(i_pc) + 16'h0002)
    else $error("Count-down branched on zero.");
  AST_BOBS_TAKEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_bobs && i_bit_value && i_byte3 == 8'hfd) |=>
    o_result.pc == $past(i_pc) && !o_result.bit_clear)
    else $error("Bit branch target wrong.");
  AST_BACB_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_bacb) |=> o_result.bit_clear == $past(i_bit_value))
    else $error("Branch-and-clear write wrong.");
  AST_BOC_WRAP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_boc && i_carry && i_pc == 16'hfffe && i_byte2 == 8'h01) |=>
    o_result.pc == 16'h0001)
    else $error("Carry branch wrap wrong.");

  // ----------------------------------------
  // Per-rule checks
  // ----------------------------------------
  AST_FIX_KEEP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix) |=> o_result.breg == $past(i_breg) &&
    o_result.pointer_pair == $past(i_pointer_pair))
    else $error("Fixup touched other state.");
  AST_FIX_LO_KEEP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix && !i_nibble_carry_flag && i_acc[3:0] <= 4'h9) |=>
    o_result.acc[3:0] == $past(i_acc[3:0]))
    else $error("Fixup changed a valid low digit.");
  AST_FIX_HI_SKIP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix && !i_carry && !i_nibble_carry_flag && i_acc[3:0] <= 4'h9 &&
    i_acc[7:4] <= 4'h9) |=> o_result.acc == $past(i_acc) && !o_result.carry)
    else $error("Fixup changed a valid value.");
  AST_FIX_HI_ADD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_fix && i_carry && !i_nibble_carry_flag && i_acc[3:0] <= 4'h9) |=>
    o_result.acc[7:4] == $past(i_acc[7:4]) + 4'h6 && o_result.carry)
    else $error("Fixup high digit wrong.");
  AST_DEC_FLAGS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_dec) |=> o_result.carry == $past(i_carry) &&
    o_result.signed_excess_flag == $past(i_signed_excess_flag))
    else $error("Decrement changed a flag.");
  AST_DEC_MEM: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_dec && !is_dec_a) |=> o_result.wr_en &&
    o_result.wr_data == $past(i_operand) - 8'h01)
    else $error("Decrement write wrong.");
  AST_DEC_ACC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_dec_a) |=>
    o_result.acc == $past(i_acc) - 8'h01 && !o_result.wr_en)
    else $error("Decrement of A wrong.");
  AST_DEC_RN_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode[7:3] == 5'h03) |=> o_result.target == abx_pkg::ABX_OP_BANK &&
    o_result.sel == $past(i_opcode[2:0]))
    else $error("Bank decrement decode wrong.");
  AST_DEC_IND_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode[7:1] == 7'h0b) |=>
    o_result.target == abx_pkg::ABX_OP_INDIRECT)
    else $error("Indirect decrement decode wrong.");
  AST_DEC_DIR_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode == 8'h15) |=> o_result.target == abx_pkg::ABX_OP_DIRECT &&
    o_result.wr_data == $past(i_operand) - 8'h01)
    else $error("Direct decrement decode wrong.");
  AST_INC_FLAGS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_inc) |=> o_result.carry == $past(i_carry) &&
    o_result.signed_excess_flag == $past(i_signed_excess_flag))
    else $error("Increment changed a flag.");
  AST_INC_ACC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_inc_a) |=>
    o_result.acc == $past(i_acc) + 8'h01 && !o_result.wr_en)
    else $error("Increment of A wrong.");
  AST_INC_MEM: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_inc && !is_inc_a) |=> o_result.wr_en &&
    o_result.wr_data == $past(i_operand) + 8'h01)
    else $error("Increment write wrong.");
  AST_INC_RN_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode[7:3] == 5'h01) |=> o_result.target == abx_pkg::ABX_OP_BANK &&
    o_result.sel == $past(i_opcode[2:0]))
    else $error("Bank increment decode wrong.");
  AST_INC_IND_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode[7:1] == 7'h03) |=>
    o_result.target == abx_pkg::ABX_OP_INDIRECT)
    else $error("Indirect increment decode wrong.");
  AST_PTR_FLAGS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode == 8'ha3) |=> o_result.carry == $past(i_carry) &&
    o_result.pointer_pair == $past(i_pointer_pair) + 16'h0001)
    else $error("Pointer increment wrong.");
  AST_DIV_CARRY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_div) |=>
    !o_result.carry)
    else $error("Divide left carry set.");
  AST_DIV_EXACT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_div && i_breg != 8'h00) |=> {8'h00, o_result.acc} * {8'h00, $past(i_breg)}
    + {8'h00, o_result.breg} == {8'h00, $past(i_acc)} && o_result.breg < $past(i_breg))
    else $error("Divide quotient or remainder wrong.");
  AST_CDB_TAKEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_cdb_rn && i_operand != 8'h01) |=> o_result.pc == $past(i_pc) +
    16'h0002 + {{8{$past(i_byte2[7])}}, $past(i_byte2)})
    else $error("Count-down branch target wrong.");
  AST_CDB_FLAGS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_cdb) |=> o_result.carry == $past(i_carry) && o_result.wr_en &&
    o_result.signed_excess_flag == $past(i_signed_excess_flag))
    else $error("Count-down changed a flag.");
  AST_CDB_DIR_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode == 8'hd5) |=> o_result.target == abx_pkg::ABX_OP_DIRECT &&
    o_result.wr_data == $past(i_operand) - 8'h01)
    else $error("Direct count-down decode wrong.");
  AST_CDB_RN_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode[7:3] == 5'h1b) |=> o_result.target == abx_pkg::ABX_OP_BANK &&
    o_result.sel == $past(i_opcode[2:0]))
    else $error("Bank count-down decode wrong.");
  AST_BOBS_SEQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_bobs && !i_bit_value) |=>
    o_result.pc == $past(i_pc) + 16'h0003 && !o_result.bit_clear)
    else $error("Bit branch fall-through wrong.");
  AST_BOBS_FLAGS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_bobs) |=> o_result.carry == $past(i_carry) && !o_result.wr_en &&
    o_result.signed_excess_flag == $past(i_signed_excess_flag))
    else $error("Bit branch changed state.");
  AST_BACB_SEQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_bacb && !i_bit_value) |=>
    o_result.pc == $past(i_pc) + 16'h0003)
    else $error("Branch-and-clear fall-through wrong.");
  AST_BACB_JUMP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_bacb && i_bit_value) |=> o_result.pc == $past(i_pc) + 16'h0003 +
    {{8{$past(i_byte3[7])}}, $past(i_byte3)})
    else $error("Branch-and-clear target wrong.");
  AST_BOC_SEQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_boc && !i_carry) |=>
    o_result.pc == $past(i_pc) + 16'h0002 && !o_result.carry)
    else $error("Carry branch fall-through wrong.");
  AST_BOC_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode == 8'h40) |=> o_result.target == abx_pkg::ABX_OP_NONE &&
    o_result.carry == $past(i_carry))
    else $error("Carry branch decode wrong.");
  AST_BOBS_DEC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && i_opcode == 8'h20) |=>
    o_result.target == abx_pkg::ABX_OP_BIT && !o_result.bit_clear)
    else $error("Bit branch decode wrong.");
  AST_REL_SIGN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_valid && is_boc && i_carry && i_byte2[7]) |=>
    o_result.pc == $past(i_pc) + 16'h0002 + {8'hff, $past(i_byte2)})
    else $error("Negative displacement wrong.");

  COV_FIX: cover property (@(posedge i_sys_clk) i_valid && is_fix && fix_carry);
  COV_DIV0: cover property (@(posedge i_sys_clk) i_valid && is_div && div_zero);
  COV_CDB: cover property (@(posedge i_sys_clk) i_valid && is_cdb && take);
  COV_BACB: cover property (@(posedge i_sys_clk) i_valid && is_bacb && i_bit_value);

endmodule

// file: abx_pkg.sv
package abx_pkg;

  // ----------------------------------------
  // Opcodes and masks
  // ----------------------------------------
  localparam logic [7:0] OP_BCD_FIXUP = 8'hd4;
  localparam logic [7:0] OP_DEC_A = 8'h14;
  localparam logic [7:0] OP_DEC_DIR = 8'h15;
  localparam logic [7:0] OP_DEC_RN = 8'h18;
  localparam logic [7:0] OP_DEC_IND = 8'h16;
  localparam logic [7:0] OP_INC_A = 8'h04;
  localparam logic [7:0] OP_INC_DIR = 8'h05;
  localparam logic [7:0] OP_INC_RN = 8'h08;
  localparam logic [7:0] OP_INC_IND = 8'h06;
  localparam logic [7:0] OP_INC_PTR = 8'ha3;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_CDB_RN = 8'hd8;
  localparam logic [7:0] OP_CDB_DIR = 8'hd5;
  localparam logic [7:0] OP_BOBS = 8'h20;
  localparam logic [7:0] OP_BACB = 8'h10;
  localparam logic [7:0] OP_BOC = 8'h40;
  localparam logic [7:0] MASK_RN = 8'hf8;
  localparam logic [7:0] MASK_IND = 8'hfe;

  // ----------------------------------------
  // Arithmetic constants
  // ----------------------------------------
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;

  // ----------------------------------------
  // Operand kinds and the answer bundle
  // ----------------------------------------
  typedef enum logic [2:0] {
    ABX_OP_NONE = 3'h0,
    ABX_OP_ACC = 3'h1,
    ABX_OP_BANK = 3'h2,
    ABX_OP_DIRECT = 3'h3,
    ABX_OP_INDIRECT = 3'h4,
    ABX_OP_BIT = 3'h5
  } abx_target_e;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] breg;
    logic carry;
    logic signed_excess_flag;
    logic [15:0] pointer_pair;
    logic [15:0] pc;
    abx_target_e target;
    logic [2:0] sel;
    logic [7:0] wr_data;
    logic wr_en;
    logic bit_clear;
    logic known;
  } abx_result_s;

endpackage

// file: abx_prog_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// Program memory model
// ----------------------------------------
module abx_prog_mem (
  // Fetch address
  input wire logic [15:0] i_pc,
  // Instruction bytes
  output logic [7:0] o_opcode,
  output logic [7:0] o_byte2,
  output logic [7:0] o_byte3
);
  // Only one page is held, so addresses alias; a fetch across 0ffffh wraps as the core does.
  logic [7:0] mem [256];
  logic [7:0] lo;
  assign lo = i_pc[7:0];
  assign o_opcode = mem[lo];
  assign o_byte2 = mem[lo + 8'h01];
  assign o_byte3 = mem[lo + 8'h02];
endmodule

// file: arith_branch_instr_exec_tb_top.sv
`timescale 1ns/1ps
module arith_branch_instr_exec_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_valid = 1'b0;
  logic [15:0] i_pc = 16'h0000;
  logic [15:0] ptr = 16'h0000;
  logic [7:0] acc = 8'h00, breg = 8'h00, opnd = 8'h00;
  logic cy = 1'b0, ac = 1'b0, ov = 1'b0, bitv = 1'b0;
  logic [7:0] op, b2, b3;
  logic o_done;
  abx_pkg::abx_result_s res;
  int fails = 0;
  int n_checks = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  abx_prog_mem abx_prog_mem_inst (.i_pc(i_pc), .o_opcode(op), .o_byte2(b2), .o_byte3(b3));
  abx_exec abx_exec_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_valid(i_valid),
    .i_opcode(op), .i_byte2(b2), .i_byte3(b3), .i_pc(i_pc), .i_acc(acc), .i_breg(breg),
    .i_carry(cy), .i_nibble_carry_flag(ac), .i_signed_excess_flag(ov),
    .i_pointer_pair(ptr), .i_operand(opnd), .i_bit_value(bitv), .o_done(o_done),
    .o_result(res));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic st(input logic [7:0] a, bb, od, input logic c, h, v, bt);
    acc = a;
    breg = bb;
    opnd = od;
    cy = c;
    ac = h;
    ov = v;
    bitv = bt;
  endtask
  // The bytes go into memory a cycle ahead of the sampling edge, so fetch is settled.
  task automatic run(input logic [15:0] pc, input logic [7:0] o, r2, r3);
    @(posedge i_sys_clk);
    #1;
    abx_prog_mem_inst.mem[pc[7:0]] = o;
    abx_prog_mem_inst.mem[pc[7:0] + 8'h01] = r2;
    abx_prog_mem_inst.mem[pc[7:0] + 8'h02] = r3;
    i_pc = pc;
    i_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_valid = 1'b0;
    chk(16'(o_done), 16'h0001);
  endtask
  task automatic br(input logic [15:0] pc, input logic [7:0] o, r2, r3, input logic [15:0] e);
    run(pc, o, r2, r3);
    chk(res.pc, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic bcd1(input logic [7:0] a, input logic c, h, input logic [7:0] ea, input logic ec);
    st(a, 8'h00, 8'h00, c, h, 1'b1, 1'b0);
    run(16'h0010, 8'hd4, 8'h00, 8'h00);
    chk(16'(res.acc), 16'(ea));
    chk(16'(res.carry), 16'(ec));
    chk(16'(res.signed_excess_flag), 16'h0001);
  endtask
  task automatic t_step(input logic [7:0] ops [4], input logic [7:0] start, ev);
    abx_pkg::abx_target_e tg [4];
    tg = '{abx_pkg::ABX_OP_ACC, abx_pkg::ABX_OP_BANK, abx_pkg::ABX_OP_DIRECT,
      abx_pkg::ABX_OP_INDIRECT};
    for (int k = 0; k < 4; k++) begin
      st(start, 8'h00, start, 1'b1, 1'b1, 1'b1, 1'b0);
      run(16'h0020, ops[k], 8'h90, 8'h00);
      chk(16'(res.target), 16'(tg[k]));
      chk(16'({res.carry, res.signed_excess_flag}), 16'h0003);
      if (k == 0) begin
        chk(16'(res.acc), 16'(ev));
      end else begin
        chk(16'({res.wr_en, res.wr_data}), 16'({1'b1, ev}));
        chk(16'(res.sel), 16'(ops[k][2:0]));
      end
    end
  endtask
  task automatic t_div();
    st(8'hfb, 8'h12, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    run(16'h0030, 8'h84, 8'h00, 8'h00);
    chk({res.acc, res.breg}, 16'h0d11);
    chk(16'({res.carry, res.signed_excess_flag}), 16'h0000);
    st(8'h40, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    run(16'h0030, 8'h84, 8'h00, 8'h00);
    chk(16'({res.carry, res.signed_excess_flag}), 16'h0001);
  endtask
  task automatic t_ptr();
    ptr = 16'h12ff;
    run(16'h0038, 8'ha3, 8'h00, 8'h00);
    chk(res.pointer_pair, 16'h1300);
    ptr = 16'hffff;
    run(16'h0038, 8'ha3, 8'h00, 8'h00);
    chk(res.pointer_pair, 16'h0000);
  endtask
  task automatic t_cdb();
    st(8'h00, 8'h00, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0);
    br(16'h0040, 8'hdd, 8'h10, 8'h00, 16'h0042);
    chk(16'({res.wr_data, 5'h00, res.sel}), 16'h0005);
    opnd = 8'h00;
    br(16'h0040, 8'hdd, 8'h10, 8'h00, 16'h0052);
    chk(16'(res.wr_data), 16'h00ff);
    opnd = 8'h05;
    br(16'h0050, 8'hd5, 8'h30, 8'hf0, 16'h0043);
    chk(16'({res.carry, res.wr_data}), 16'h0104);
  endtask
  task automatic t_bits();
    st(8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
    br(16'h0060, 8'h20, 8'h22, 8'h05, 16'h0068);
    chk(16'({res.bit_clear, res.carry}), 16'h0001);
    bitv = 1'b0;
    br(16'h0060, 8'h20, 8'h22, 8'h05, 16'h0063);
    bitv = 1'b1;
    br(16'h0060, 8'h20, 8'h22, 8'hfd, 16'h0060);
    bitv = 1'b0;
    br(16'h0070, 8'h10, 8'h91, 8'hfe, 16'h0073);
    chk(16'(res.bit_clear), 16'h0000);
    bitv = 1'b1;
    br(16'h0070, 8'h10, 8'h91, 8'hfe, 16'h0071);
    chk(16'(res.bit_clear), 16'h0001);
  endtask
  task automatic t_carry();
    st(8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    br(16'h0100, 8'h40, 8'h10, 8'h00, 16'h0112);
    chk(16'(res.carry), 16'h0001);
    br(16'hfffe, 8'h40, 8'h7f, 8'h00, 16'h007f);
    br(16'h0100, 8'h40, 8'h80, 8'h00, 16'h0082);
    br(16'hfffe, 8'h40, 8'h01, 8'h00, 16'h0001);
    chk(16'(res.known), 16'h0001);
    cy = 1'b0;
    br(16'hfffe, 8'h40, 8'h7f, 8'h00, 16'h0000);
    br(16'h0080, 8'ha5, 8'h00, 8'h00, 16'h0081);
    chk(16'({res.known, res.carry}), 16'h0000);
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk(16'(o_done), 16'h0000);
    i_rst = 1'b0;
    bcd1(8'hbe, 1'b0, 1'b0, 8'h24, 1'b1);
    bcd1(8'hc9, 1'b0, 1'b0, 8'h29, 1'b1);
    bcd1(8'h12, 1'b1, 1'b0, 8'h72, 1'b1);
    bcd1(8'h34, 1'b0, 1'b1, 8'h3a, 1'b0);
    bcd1(8'h0a, 1'b0, 1'b0, 8'h10, 1'b0);
    bcd1(8'h45, 1'b0, 1'b0, 8'h45, 1'b0);
    bcd1(8'ha0, 1'b0, 1'b0, 8'h00, 1'b1);
    t_step('{8'h14, 8'h1b, 8'h15, 8'h17}, 8'h00, 8'hff);
    t_step('{8'h04, 8'h0e, 8'h05, 8'h06}, 8'hff, 8'h00);
    t_div();
    t_ptr();
    t_cdb();
    t_bits();
    t_carry();
    tally_and_finish();
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule
